// >>> design/ptpc_pkg.sv
// constants shared by both ends of the transmit parallel link
// assumes both ends run from one 25 MHz clock; no other context needed
package ptpc_pkg;

  // power-state request codes
  localparam logic [1:0] PS_P0  = 2'b00;
  localparam logic [1:0] PS_P0S = 2'b01;
  localparam logic [1:0] PS_P1  = 2'b10;

  // timing
  localparam int CLK_MHZ         = 25;
  localparam int P1_RECOVERY_US  = 64;
  // longest time, exact at 25 MHz
  localparam int P1_RECOVERY_CYC = P1_RECOVERY_US * CLK_MHZ;
  localparam int PS_SHORT_CYC    = 8;
  localparam int STATUS_HOLD_CYC = 8;
  localparam int MODE_SETTLE_CYC = 3;
  localparam int WAIT_W          = 11;

  // link clock divider, phases of the controller's clock
  localparam logic [2:0] LINK_HALF     = 3'h4;
  localparam logic [2:0] PH_LOAD_FIRST = 3'h6;
  localparam logic [2:0] PH_LOAD_SECND = 3'h2;

  // register port of the controller end
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TXWORD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

  // control fields
  localparam int CTRL_PS_LSB    = 0;
  localparam int CTRL_EIDLE_BIT = 2;
  localparam int CTRL_DDR_BIT   = 3;
  localparam int CTRL_RST_BIT   = 4;
  localparam int CTRL_W         = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h14;

  // transmit word fields
  localparam int WORD_K_LSB = 16;
  localparam int WORD_W     = 18;

  // status fields
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_SEEN_BIT = 1;

endpackage

// >>> design/ptpc_link_if.sv
// the parallel transmit link between controller and device
// assumes the bench joins one device end and one controller end here
`timescale 1ns/100ps
interface ptpc_link_if;
  logic        link_rst_n;
  logic        tx_clk;
  logic [15:0] tx_data;
  logic [1:0]  tx_datak;
  logic [1:0]  power_req;
  logic        tx_elec_idle;
  logic        double_rate_sel;
  logic        phy_status;

  modport dev (
    input  link_rst_n,
    input  tx_clk,
    input  tx_data,
    input  tx_datak,
    input  power_req,
    input  tx_elec_idle,
    input  double_rate_sel,
    output phy_status
  );

  modport ctrl (
    output link_rst_n,
    output tx_clk,
    output tx_data,
    output tx_datak,
    output power_req,
    output tx_elec_idle,
    output double_rate_sel,
    input  phy_status
  );
endinterface

// >>> design/ptpc_device.sv
// device end: takes the parallel transmit bus and power requests
// assumes link pins are asynchronous to clk and the link clock is well
// below clk/4 so every link clock phase is seen at least twice
//
// What this block does
// - device reset input active low, asynchronous
// - power code 00 selects full-power P0
// - power code 01 selects short-latency P0s
// - code 10 selects P1, recovery within 64us
// - status output signals each completed operation
// - select low at release: single-rate, 16-bit capture
// - select high: double-rate, low byte both edges
// - single-rate: low byte first, high second
// - double-rate: rising byte first, falling second
// - controller ties upper data low in double-rate
// - controller ties upper qualifier low in double-rate
// - single-rate: qualifier bit per data byte
// - double-rate: qualifier sampled with its byte
// - qualifier zero data, one control symbol
// - P0 idle low means valid data; else high
`timescale 1ns/100ps
module ptpc_device
  import ptpc_pkg::*;
(
  // clock and system reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // link to the controller
  ptpc_link_if.dev        link,
  // serial side events
  input  wire logic       rx_detect_done,
  // symbol stream toward the serializer
  output logic            sym_valid,
  output logic [7:0]      sym_data,
  output logic            sym_ctrl,
  output logic [1:0]      cur_power,
  output logic            double_rate
);

  typedef enum logic {PT_STABLE, PT_CHANGE} ptpc_pt_e;

  // synchronised link inputs: {sel, power, idle, qualifiers, data}
  localparam int IN_W = 22;

  typedef struct packed {
    logic [2:0]        clk_s;
    logic [IN_W-1:0]   in_s1;
    logic [IN_W-1:0]   in_s2;
    logic [1:0]        settle;
    logic              mode_ok;
    logic              ddr;
    ptpc_pt_e          pt;
    logic [1:0]        cur_ps;
    logic [1:0]        target_ps;
    logic [WAIT_W-1:0] wait_cnt;
    logic [3:0]        stat_cnt;
    logic              stat_o;
    logic              hi_pend;
    logic [8:0]        hi_sym;
    logic              sym_valid;
    logic [7:0]        sym_data;
    logic              sym_ctrl;
  } ptpc_dev_s;

  localparam ptpc_dev_s DEV_RESET = '{
    clk_s:     3'h0,
    in_s1:     22'h000000,
    in_s2:     22'h000000,
    settle:    2'h0,
    mode_ok:   1'b0,
    ddr:       1'b0,
    pt:        PT_STABLE,
    cur_ps:    PS_P1,
    target_ps: PS_P1,
    wait_cnt:  11'h000,
    stat_cnt:  4'h0,
    stat_o:    1'b0,
    hi_pend:   1'b0,
    hi_sym:    9'h000,
    sym_valid: 1'b0,
    sym_data:  8'h00,
    sym_ctrl:  1'b0
  };

  ptpc_dev_s st_r;
  ptpc_dev_s st_nxt;

  logic [15:0] in_data;
  logic [1:0]  in_k;
  logic        in_idle;
  logic [1:0]  in_ps;
  logic        in_sel;
  logic        clk_rise;
  logic        clk_fall;
  logic        send_ok;

  // second stage only; the first stage feeds nothing but the second
  assign in_data  = st_r.in_s2[15:0];
  assign in_k     = st_r.in_s2[17:16];
  assign in_idle  = st_r.in_s2[18];
  assign in_ps    = st_r.in_s2[20:19];
  assign in_sel   = st_r.in_s2[21];
  assign clk_rise = st_r.clk_s[1] & ~st_r.clk_s[2];
  assign clk_fall = ~st_r.clk_s[1] & st_r.clk_s[2];

  assign send_ok = st_r.mode_ok && (st_r.cur_ps == PS_P0) &&
                   (st_r.pt == PT_STABLE) && !in_idle;

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_s = {st_r.clk_s[1:0], link.tx_clk};
    st_nxt.in_s1 = {link.double_rate_sel, link.power_req, link.tx_elec_idle,
                    link.tx_datak, link.tx_data};
    st_nxt.in_s2 = st_r.in_s1;

    if (!st_r.mode_ok) begin
      st_nxt.settle = st_r.settle + 2'h1;
      if (st_r.settle == 2'(MODE_SETTLE_CYC)) begin
        st_nxt.mode_ok = 1'b1;
        st_nxt.ddr = in_sel;
      end
    end

    // power-state sequencer
    if (st_r.stat_cnt != 4'h0) begin
      st_nxt.stat_cnt = st_r.stat_cnt - 4'h1;
    end
    unique case (st_r.pt)
      PT_STABLE: begin
        if (st_r.mode_ok && (in_ps != st_r.cur_ps) &&
            (in_ps == PS_P0 || in_ps == PS_P0S || in_ps == PS_P1)) begin
          st_nxt.target_ps = in_ps;
          st_nxt.pt        = PT_CHANGE;
          if (st_r.cur_ps == PS_P1) begin
            st_nxt.wait_cnt = WAIT_W'(P1_RECOVERY_CYC - 1);
          end else begin
            st_nxt.wait_cnt = WAIT_W'(PS_SHORT_CYC - 1);
          end
        end
      end
      PT_CHANGE: begin
        if (st_r.wait_cnt == '0) begin
          st_nxt.cur_ps   = st_r.target_ps;
          st_nxt.pt       = PT_STABLE;
          st_nxt.stat_cnt = 4'(STATUS_HOLD_CYC);
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 1'b1;
        end
      end
    endcase
    if (rx_detect_done) begin
      st_nxt.stat_cnt = 4'(STATUS_HOLD_CYC);
    end
    st_nxt.stat_o = (st_nxt.stat_cnt != 4'h0);

    // symbol capture
    st_nxt.sym_valid = 1'b0;
    if (st_r.hi_pend) begin
      st_nxt.hi_pend   = 1'b0;
      st_nxt.sym_valid = 1'b1;
      st_nxt.sym_data  = st_r.hi_sym[7:0];
      st_nxt.sym_ctrl  = st_r.hi_sym[8];
    end else if (clk_rise && send_ok) begin
      st_nxt.sym_valid = 1'b1;
      st_nxt.sym_data  = in_data[7:0];
      st_nxt.sym_ctrl  = in_k[0];
      if (!st_r.ddr) begin
        st_nxt.hi_pend = 1'b1;
        st_nxt.hi_sym  = {in_k[1], in_data[15:8]};
      end
    end else if (clk_fall && send_ok && st_r.ddr) begin
      st_nxt.sym_valid = 1'b1;
      st_nxt.sym_data  = in_data[7:0];
      st_nxt.sym_ctrl  = in_k[0];
    end
  end

  // link reset acts without the clock; release is not synchronised
  // the settle count absorbs the first unsafe cycles
  always_ff @(posedge clk or negedge link.link_rst_n) begin
    if (!link.link_rst_n) begin
      st_r <= DEV_RESET;
    end else if (sys_rst) begin
      st_r <= DEV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.phy_status = st_r.stat_o;
  assign sym_valid       = st_r.sym_valid;
  assign sym_data        = st_r.sym_data;
  assign sym_ctrl        = st_r.sym_ctrl;
  assign cur_power       = st_r.cur_ps;
  assign double_rate     = st_r.ddr;

endmodule

// >>> design/ptpc_ctrl.sv
// controller end: drives the link from software registers
// assumes a plain register port on clk; the device answers on phy_status
`timescale 1ns/100ps
module ptpc_ctrl
  import ptpc_pkg::*;
(
  // clock and system reset
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  // register port
  input  wire logic [ptpc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ptpc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [ptpc_pkg::DATA_W-1:0]    reg_rdata,
  // link to the device
  ptpc_link_if.ctrl                           link
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [WORD_W-1:0] word;
    logic              pend;
    logic [WORD_W-1:0] fly;
    logic              active;
    logic [2:0]        phase;
    logic              clk_o;
    logic [15:0]       dout;
    logic [1:0]        kout;
    logic              eidle_o;
    logic [2:0]        ps_s;
    logic              seen;
    logic [DATA_W-1:0] rdata;
  } ptpc_ctl_s;

  localparam ptpc_ctl_s CTL_RESET = '{
    ctrl:    CTRL_RESET,
    word:    18'h00000,
    pend:    1'b0,
    fly:     18'h00000,
    active:  1'b0,
    phase:   3'h0,
    // phase 0 is a high phase; a low value here would shorten the first pulse
    clk_o:   1'b1,
    dout:    16'h0000,
    kout:    2'h0,
    eidle_o: 1'b1,
    ps_s:    3'h0,
    seen:    1'b0,
    rdata:   32'h00000000
  };

  ptpc_ctl_s st_r;
  ptpc_ctl_s st_nxt;

  logic       ddr;
  logic [1:0] ps_req;
  logic       hold_idle;

  assign ddr       = st_r.ctrl[CTRL_DDR_BIT];
  assign ps_req    = st_r.ctrl[CTRL_PS_LSB +: 2];
  assign hold_idle = (ps_req != PS_P0) || st_r.ctrl[CTRL_EIDLE_BIT] ||
                     st_r.ctrl[CTRL_RST_BIT];

  always_comb begin
    st_nxt = st_r;
    // link clock: divide by eight, high for the first half
    st_nxt.phase = st_r.phase + 3'h1;
    st_nxt.clk_o = (st_nxt.phase < LINK_HALF);

    // register writes; a word written while one waits is dropped
    if (reg_wr && reg_addr == REG_CTRL) begin
      st_nxt.ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (reg_wr && reg_addr == REG_TXWORD && !st_r.pend) begin
      st_nxt.word = reg_wdata[WORD_W-1:0];
      st_nxt.pend = 1'b1;
    end

    // data changes mid-phase so both edges see settled pins
    if (st_r.phase == PH_LOAD_FIRST) begin
      if (st_r.pend && !hold_idle) begin
        st_nxt.pend    = 1'b0;
        st_nxt.active  = 1'b1;
        st_nxt.fly     = st_r.word;
        st_nxt.eidle_o = 1'b0;
        st_nxt.dout = st_r.word[15:0];
        st_nxt.kout = st_r.word[WORD_K_LSB +: 2];
        if (ddr) begin
          st_nxt.dout = {8'h00, st_r.word[7:0]};
          st_nxt.kout = {1'b0, st_r.word[WORD_K_LSB]};
        end
      end else begin
        st_nxt.active  = 1'b0;
        st_nxt.eidle_o = 1'b1;
        st_nxt.dout    = 16'h0000;
        st_nxt.kout    = 2'h0;
      end
    end
    // second byte with its qualifier for the falling edge
    if (st_r.phase == PH_LOAD_SECND && st_r.active && ddr) begin
      st_nxt.dout = {8'h00, st_r.fly[15:8]};
      st_nxt.kout = {1'b0, st_r.fly[WORD_K_LSB + 1]};
    end
    if (hold_idle) begin
      st_nxt.eidle_o = 1'b1;
      st_nxt.active  = 1'b0;
    end

    // completion seen; a new event beats a clear
    st_nxt.ps_s = {st_r.ps_s[1:0], link.phy_status};
    if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_SEEN_BIT]) begin
      st_nxt.seen = 1'b0;
    end
    if (st_r.ps_s[1] && !st_r.ps_s[2]) begin
      st_nxt.seen = 1'b1;
    end

    // read data stands one cycle only
    st_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   st_nxt.rdata = DATA_W'(st_r.ctrl);
        REG_TXWORD: st_nxt.rdata = DATA_W'(st_r.word);
        REG_STATUS: st_nxt.rdata = DATA_W'({st_r.seen, st_r.pend});
        default:    st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= CTL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // device reset driven low while the reset bit is set
  assign link.link_rst_n      = ~st_r.ctrl[CTRL_RST_BIT];
  assign link.tx_clk          = st_r.clk_o;
  assign link.tx_data         = st_r.dout;
  assign link.tx_datak        = st_r.kout;
  // requested state straight from the register
  assign link.power_req       = ps_req;
  assign link.tx_elec_idle    = st_r.eidle_o;
  // rate select held across the reset release
  assign link.double_rate_sel = ddr;
  assign reg_rdata            = st_r.rdata;

endmodule

// >>> verification/ptpc_link_monitor.sv
// checker watching the link between the controller and device ends
// assumes the bench wires every input to the matching link signal
`timescale 1ns/100ps
module ptpc_link_monitor
  import ptpc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // link signals
  input wire logic        link_rst_n,
  input wire logic        tx_clk,
  input wire logic [15:0] tx_data,
  input wire logic [1:0]  tx_datak,
  input wire logic [1:0]  power_req,
  input wire logic        tx_elec_idle,
  input wire logic        double_rate_sel,
  input wire logic        phy_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // long answers are counted here, a delay range that long is too costly
  localparam int ANSWER_LIMIT = 1700;
  logic        pw_wait;
  logic [10:0] pw_cnt;
  logic        rl_wait;
  logic [10:0] rl_cnt;

  // code 11 is ignored by the device, so a change to it gets no answer; a change from it is answered only if the new code differs from the current state
  always @(posedge clk) begin
    if (sys_rst) begin
      pw_wait <= 1'b0;
      pw_cnt  <= 11'h000;
      rl_wait <= 1'b0;
      rl_cnt  <= 11'h000;
    end else begin
      if ($changed(power_req) && power_req != 2'h3 && $past(power_req) != 2'h3) begin
        pw_wait <= 1'b1;
        pw_cnt  <= 11'h000;
      end else if ($rose(phy_status) || !link_rst_n) begin
        pw_wait <= 1'b0;
      end else if (pw_wait) begin
        pw_cnt <= pw_cnt + 11'h001;
      end
      if ($rose(link_rst_n)) begin
        rl_wait <= 1'b1;
        rl_cnt  <= 11'h000;
      end else if ($rose(phy_status) || !link_rst_n) begin
        rl_wait <= 1'b0;
      end else if (rl_wait) begin
        rl_cnt <= rl_cnt + 11'h001;
      end
    end
  end

  // a link reset in mid-pulse legally cuts the pulse short
  property p_status_hold;
    disable iff (sys_rst || !link_rst_n)
    $rose(phy_status) |-> phy_status[*8] ##1 !phy_status;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status pulse length");

  property p_reset_quiet;
    !link_rst_n |=> !phy_status;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("status in reset");

  property p_upper_zero;
    double_rate_sel && !tx_elec_idle |-> tx_data[15:8] == 8'h00 && !tx_datak[1];
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lane driven");

  property p_idle_low_power;
    power_req != PS_P0 && $past(power_req) != PS_P0 |-> tx_elec_idle;
  endproperty
  a_idle_low_power: assert property (p_idle_low_power) else $error("idle dropped");

  property p_data_in_p0;
    $fell(tx_elec_idle) |-> power_req == PS_P0;
  endproperty
  a_data_in_p0: assert property (p_data_in_p0) else $error("data outside P0");

  property p_clk_period;
    $rose(tx_clk) |-> tx_clk[*4] ##1 !tx_clk[*4] ##1 tx_clk;
  endproperty
  a_clk_period: assert property (p_clk_period) else $error("link clock shape");

  // the bus must be settled at either edge, ddr samples both
  property p_data_stable;
    $changed(tx_clk) |-> $stable(tx_data) && $stable(tx_datak);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("bus moves at edge");

  property p_power_answer;
    pw_wait |-> pw_cnt < ANSWER_LIMIT;
  endproperty
  a_power_answer: assert property (p_power_answer) else $error("no power answer");

  property p_release_answer;
    rl_wait |-> rl_cnt < ANSWER_LIMIT;
  endproperty
  a_release_answer: assert property (p_release_answer) else $error("no wake answer");
endmodule

// >>> verification/pipe_tx_port_power_ctrl_tb.sv
// bench joining controller and device ends over the link interface
// assumes one clock for both ends; software reaches only the registers
`timescale 1ns/100ps
module pipe_tx_port_power_ctrl_tb;
  import ptpc_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              rx_detect_done;
  logic              sym_valid;
  logic [7:0]        sym_data;
  logic              sym_ctrl;
  logic [1:0]        cur_power;
  logic              double_rate;
  logic [8:0]        exp_q[$];
  logic [31:0]       lfsr;
  int                errors;
  int                check_count;

  ptpc_link_if link_if();
  ptpc_device u_ptpc_device (.clk(clk), .sys_rst(sys_rst), .link(link_if),
    .rx_detect_done(rx_detect_done), .sym_valid(sym_valid), .sym_data(sym_data),
    .sym_ctrl(sym_ctrl), .cur_power(cur_power), .double_rate(double_rate));
  ptpc_ctrl u_ptpc_ctrl (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link_if));
  ptpc_link_monitor u_ptpc_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .link_rst_n(link_if.link_rst_n), .tx_clk(link_if.tx_clk),
    .tx_data(link_if.tx_data), .tx_datak(link_if.tx_datak),
    .power_req(link_if.power_req), .tx_elec_idle(link_if.tx_elec_idle),
    .double_rate_sel(link_if.double_rate_sel), .phy_status(link_if.phy_status));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // clearing waits out the pulse; the sticky bit sets only on a rising edge of the status
  task automatic wait_seen();
    logic [DATA_W-1:0] d;
    d = '0;
    for (int i = 0; i < 1000 && d[STAT_SEEN_BIT] !== 1'b1; i++)
      rd(REG_STATUS, d);
    chk(d[STAT_SEEN_BIT], "no completion seen");
    if (d[STAT_SEEN_BIT] !== 1'b1)
      summarize();
    repeat (STATUS_HOLD_CYC + 2) @(posedge clk);
    wr(REG_STATUS, 32'h0000_0002);
  endtask

  task automatic send_word();
    logic [17:0] w;
    lfsr = lfsr_next(lfsr);
    w = lfsr[17:0];
    exp_q.push_back({w[16], w[7:0]});
    exp_q.push_back({w[17], w[15:8]});
    wr(REG_TXWORD, {14'h0000, w});
    for (int i = 0; i < 100 && exp_q.size() > 0; i++)
      @(posedge clk);
    chk(exp_q.size() == 0, "symbols missing");
  endtask

  always @(posedge clk) begin
    if (!sys_rst && sym_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk(1'b0, "unexpected symbol");
      else
        chk(exp_q.pop_front() === {sym_ctrl, sym_data}, "symbol mismatch");
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    logic [DATA_W-1:0] d;
    logic [1:0]        ps;
    sys_rst        = 1'b1;
    reg_addr       = '0;
    reg_wdata      = '0;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    rx_detect_done = 1'b0;
    lfsr           = 32'h1CEF_814E;
    errors         = 0;
    check_count    = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CTRL, d);
    chk(d === {27'h0, CTRL_RESET}, "control reset value");
    rd(4'hC, d);
    chk(d === 32'h0, "unmapped read");
    $display("test reset done");
    wr(REG_CTRL, 32'h0);
    wait_seen();
    chk(cur_power === PS_P0 && double_rate === 1'b0, "single rate P0");
    repeat (4) send_word();
    $display("test single rate done");
    for (int i = 1; i < 3; i++) begin
      ps = 2'(i);
      wr(REG_CTRL, {30'h0, ps});
      wait_seen();
      chk(cur_power === ps, "low power entry");
      wr(REG_CTRL, 32'h0);
      wait_seen();
      chk(cur_power === PS_P0, "back to full power");
    end
    wr(REG_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    chk(cur_power === PS_P0, "code 11 ignored");
    wr(REG_CTRL, 32'h0);
    @(posedge clk);
    rx_detect_done <= 1'b1;
    @(posedge clk);
    rx_detect_done <= 1'b0;
    wait_seen();
    $display("test power states done");
    wr(REG_CTRL, 32'h18);
    repeat (4) @(posedge clk);
    chk(cur_power === PS_P1, "device held in reset");
    wr(REG_CTRL, 32'h08);
    wait_seen();
    chk(double_rate === 1'b1, "double rate latched");
    repeat (4) send_word();
    wr(REG_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    chk(double_rate === 1'b1, "mode held");
    $display("test double rate done");
    summarize();
  end
endmodule
